// file: oapd_pkg.sv
// package for the group b output auto power-down source selection block
// Contract
// RL1 - bit 8 of select 0 lets temperature alarm power down group b pins
// RL2 - bit 5 of select 0 lets second adc alarm power down group b pins
// RL3 - bit 4 of select 0 lets first adc alarm power down group b pins
// RL4 - bit 1 lets second current-sense alarm power down group b pins
// RL5 - bit 0 lets first current-sense alarm power down group b pins
// RL6 - selected alarm powers down only pins enabled in the pin enable register
// RL7 - select 1 at 4Bh resets to 1833h; bits 13,12,11,5,4,1,0 writable
// RL8 - select 1 picks alarm-in, reference, thermal, two neg and two pos supplies
// RL9 - per-pin request is OR of selected active alarms gated by pin enable
package oapd_pkg;
  localparam int unsigned NPINS = 4;
  localparam int unsigned NALARM = 12;
  // register offsets are word indices; the byte address is four times these
  localparam logic [7:0] SRC0_IDX = 8'h4A;
  localparam logic [7:0] SRC1_IDX = 8'h4B;
  localparam logic [7:0] PIN_EN_IDX = 8'h50;
  localparam logic [7:0] ALARM_IDX = 8'h51;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h52;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h53;
  localparam logic [15:0] SRC0_RST = 16'h0000;
  localparam logic [15:0] SRC0_WMASK = 16'h0133;
  localparam logic [15:0] SRC1_RST = 16'h1833;
  localparam logic [15:0] SRC1_WMASK = 16'h3833;
  localparam logic [15:0] PIN_EN_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  // select 0 field positions
  localparam int unsigned TEMP_SEL_POS = 8;
  localparam int unsigned ADC1_SEL_POS = 5;
  localparam int unsigned ADC0_SEL_POS = 4;
  localparam int unsigned SENSE1_SEL_POS = 1;
  localparam int unsigned SENSE0_SEL_POS = 0;
  // select 1 field positions
  localparam int unsigned ALMIN_SEL_POS = 13;
  localparam int unsigned REF_SEL_POS = 12;
  localparam int unsigned THERM_SEL_POS = 11;
  localparam int unsigned NEG2_SEL_POS = 5;
  localparam int unsigned NEG1_SEL_POS = 4;
  localparam int unsigned POS2_SEL_POS = 1;
  localparam int unsigned POS1_SEL_POS = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // alarm inputs, one bit per monitor
  typedef struct packed {
    logic alarm_in;
    logic reference;
    logic thermal_err;
    logic neg_supply_two;
    logic neg_supply_one;
    logic pos_supply_two;
    logic pos_supply_one;
    logic temperature;
    logic adc_two;
    logic adc_one;
    logic sense_two;
    logic sense_one;
  } oapd_alarm_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } oapd_wreq_t;
endpackage

// file: oapd_regfile.sv
// register storage for the source selects, pin enables and interrupt mask
`timescale 1ns/100ps
module oapd_regfile (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [7:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] wr_strb,
  output logic [15:0] src0_q,
  output logic [15:0] src1_q,
  output logic [15:0] pin_en_q,
  output logic [15:0] mask_q
);
  function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [15:0] nw, input logic [1:0] st, input logic [15:0] wm);
    logic [15:0] be;
    be = {{8{st[1]}}, {8{st[0]}}};
    merge = (old & ~(be & wm)) | (nw & be & wm);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src0_q <= oapd_pkg::SRC0_RST;
    end else if (wr_en && wr_idx == oapd_pkg::SRC0_IDX) begin
      src0_q <= merge(src0_q, wr_data, wr_strb, oapd_pkg::SRC0_WMASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src1_q <= oapd_pkg::SRC1_RST; // RL7
    end else if (wr_en && wr_idx == oapd_pkg::SRC1_IDX) begin
      src1_q <= merge(src1_q, wr_data, wr_strb,
          oapd_pkg::SRC1_WMASK); // RL7
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_en_q <= oapd_pkg::PIN_EN_RST;
    end else if (wr_en && wr_idx == oapd_pkg::PIN_EN_IDX) begin
      pin_en_q <= merge(pin_en_q, wr_data, wr_strb, 16'h000F);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= oapd_pkg::MASK_RST;
    end else if (wr_en && wr_idx == oapd_pkg::IRQ_MASK_IDX) begin
      mask_q <= merge(mask_q, wr_data, wr_strb, 16'h0FFF);
    end
  end
endmodule

// file: oapd_top.sv
// group b output auto power-down source selection with axi4-lite registers
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module oapd_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire oapd_pkg::oapd_alarm_t alarms,
  output logic [oapd_pkg::NPINS-1:0] group_b_pin_powerdown_q,
  output logic irq_q
);
  logic aw_hold_q;
  logic w_hold_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [15:0] src0_q;
  logic [15:0] src1_q;
  logic [15:0] pin_en_q;
  logic [15:0] mask_q;
  logic [15:0] stat_q;
  logic [15:0] stat_clr;
  logic stat_hit;
  logic [11:0] sel;
  logic any_alarm;
  logic wr_fire;
  logic wr_ok;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic [15:0] rd_val;
  logic rd_ok;

  // address decode: word index, and whether it hits a mapped register
  function automatic logic mapped(input logic [31:0] a);
    logic [7:0] i;
    i = a[9:2];
    mapped = (a[31:10] == 22'h0) && (i == oapd_pkg::SRC0_IDX ||
        i == oapd_pkg::SRC1_IDX || i == oapd_pkg::PIN_EN_IDX ||
        i == oapd_pkg::ALARM_IDX || i == oapd_pkg::IRQ_STAT_IDX ||
        i == oapd_pkg::IRQ_MASK_IDX);
  endfunction

  // write channel capture: address and data may arrive in either order
  // ready outputs are flops that hold what the hold and response state will
  // be after this edge, so they equal a decoded ready with no comb path out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else if (wr_fire) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= ~(aw_hold_q | (s_axi_awvalid & s_axi_awready))
          & ~(s_axi_bvalid & ~s_axi_bready);
      s_axi_wready <= ~(w_hold_q | (s_axi_wvalid & s_axi_wready))
          & ~(s_axi_bvalid & ~s_axi_bready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= 32'h0;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
  end

  assign wr_fire = aw_hold_q & w_hold_q;
  assign wr_ok = mapped(awaddr_q);
  assign wr_idx = awaddr_q[9:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= oapd_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? oapd_pkg::RESP_OKAY : oapd_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  oapd_regfile u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_fire & wr_ok),
    .wr_idx(wr_idx),
    .wr_data(wdata_q[15:0]),
    .wr_strb(wstrb_q[1:0]),
    .src0_q(src0_q),
    .src1_q(src1_q),
    .pin_en_q(pin_en_q),
    .mask_q(mask_q)
  );

  // selected alarms, ordered as in the alarm struct
  always_comb begin
    sel = {src1_q[oapd_pkg::ALMIN_SEL_POS] & alarms.alarm_in, // RL8
        src1_q[oapd_pkg::REF_SEL_POS] & alarms.reference, // RL8
        src1_q[oapd_pkg::THERM_SEL_POS] & alarms.thermal_err, // RL8
        src1_q[oapd_pkg::NEG2_SEL_POS] & alarms.neg_supply_two, // RL8
        src1_q[oapd_pkg::NEG1_SEL_POS] & alarms.neg_supply_one, // RL8
        src1_q[oapd_pkg::POS2_SEL_POS] & alarms.pos_supply_two, // RL8
        src1_q[oapd_pkg::POS1_SEL_POS] & alarms.pos_supply_one, // RL8
        src0_q[oapd_pkg::TEMP_SEL_POS] & alarms.temperature, // RL1
        src0_q[oapd_pkg::ADC1_SEL_POS] & alarms.adc_two, // RL2
        src0_q[oapd_pkg::ADC0_SEL_POS] & alarms.adc_one, // RL3
        src0_q[oapd_pkg::SENSE1_SEL_POS] & alarms.sense_two, // RL4
        src0_q[oapd_pkg::SENSE0_SEL_POS] & alarms.sense_one}; // RL5
    any_alarm = |sel; // RL9
  end

  // one register stage; alarm levels are taken as synchronous
  genvar gp;
  generate
    for (gp = 0; gp < oapd_pkg::NPINS; gp++) begin : g_pin
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          group_b_pin_powerdown_q[gp] <= 1'b0;
        end else begin
          group_b_pin_powerdown_q[gp] <= any_alarm & pin_en_q[gp]; // RL6 RL9
        end
      end
    end
  endgenerate

  // write-one-clear vector; the low strobe covers all twelve status bits
  // so software clears the whole field with one byte-lane write
  assign stat_hit = wr_fire & wr_ok & (wr_idx == oapd_pkg::IRQ_STAT_IDX);

  always_comb begin
    stat_clr = 16'h0;
    if (stat_hit && wstrb_q[0]) begin
      stat_clr = {4'h0, wdata_q[11:0]};
    end
  end

  // sticky raw alarm status; a new alarm wins over a write-one clear
  // in the same cycle, so no event is lost to a late clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 16'h0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | {4'h0, alarms};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // read channel: one read in flight, data registered
  // arready is the registered inverse of the next rvalid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_rready) begin
      s_axi_arready <= 1'b1;
    end
  end
  assign rd_idx = s_axi_araddr[9:2];
  assign rd_ok = mapped(s_axi_araddr);

  always_comb begin
    rd_val = 16'h0;
    if (rd_idx == oapd_pkg::SRC0_IDX) begin
      rd_val = src0_q;
    end else if (rd_idx == oapd_pkg::SRC1_IDX) begin
      rd_val = src1_q;
    end else if (rd_idx == oapd_pkg::PIN_EN_IDX) begin
      rd_val = pin_en_q;
    end else if (rd_idx == oapd_pkg::ALARM_IDX) begin
      rd_val = {4'h0, alarms};
    end else if (rd_idx == oapd_pkg::IRQ_STAT_IDX) begin
      rd_val = stat_q;
    end else if (rd_idx == oapd_pkg::IRQ_MASK_IDX) begin
      rd_val = mask_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= oapd_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? {16'h0, rd_val} : 32'h0;
      s_axi_rresp <= rd_ok ? oapd_pkg::RESP_OKAY : oapd_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// file: oapd_sva.sv
// port checker for the group b auto power-down block
`timescale 1ns/100ps
module oapd_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire oapd_pkg::oapd_alarm_t alarms,
  input wire logic [oapd_pkg::NPINS-1:0] group_b_pin_powerdown_q
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_pd_idle: assert property ((alarms == '0) |=>
    (group_b_pin_powerdown_q == '0)) else $error("power-down w/o alarm");
  chk_pd_cause: assert property ($rose(|group_b_pin_powerdown_q) |->
    $past(|alarms)) else $error("power-down rose with no alarm");
  chk_wr_latency: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_rd_latency: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response late");
  chk_b_clear: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("write response not retired");
  chk_r_clear: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("read response not retired");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  chk_err_zero: assert property (s_axi_rvalid &&
    s_axi_rresp == oapd_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
endmodule
bind oapd_top oapd_sva u_sva (.*);

// file: tb_oapd_top.sv
// self-checking bench for the auto power-down source selection block
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_oapd_top;
  localparam logic [1:0] OK = oapd_pkg::RESP_OKAY;
  localparam logic [1:0] ER = oapd_pkg::RESP_SLVERR;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq_q;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [oapd_pkg::NPINS-1:0] group_b_pin_powerdown_q;
  oapd_pkg::oapd_alarm_t alarms = '0;
  int miscompares = 0;
  int tests_run = 0;
  // select bit of each alarm, in alarm struct order from lsb
  int pos[12] = '{0, 1, 4, 5, 8, 0, 1, 4, 5, 11, 12, 13};
  always #5 aclk = ~aclk;
  oapd_top u_dut (.*);
  task automatic wr(input logic [7:0] idx, input logic [15:0] d,
    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, idx, 2'h0};
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    `CHK(s_axi_bvalid, 1'h1)
    `CHK(s_axi_bresp, er)
  endtask
  task automatic rd(input logic [7:0] idx, input logic [15:0] ed,
    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {22'h0, idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    `CHK(s_axi_rvalid, 1'h1)
    `CHK(s_axi_rdata, {16'h0, ed})
    `CHK(s_axi_rresp, er)
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // whole run is a few hundred cycles; this leaves a wide margin
  initial begin
    #300000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rd(oapd_pkg::SRC0_IDX, 16'h0000, OK);
    rd(oapd_pkg::SRC1_IDX, 16'h1833, OK);
    rd(oapd_pkg::PIN_EN_IDX, 16'h0000, OK);
    wr(oapd_pkg::SRC0_IDX, 16'hFFFF, OK);
    rd(oapd_pkg::SRC0_IDX, 16'h0133, OK);
    wr(oapd_pkg::SRC1_IDX, 16'h0000, OK);
    rd(oapd_pkg::SRC1_IDX, 16'h0000, OK);
    wr(oapd_pkg::SRC1_IDX, 16'hFFFF, OK);
    rd(oapd_pkg::SRC1_IDX, 16'h3833, OK);
    wr(8'h60, 16'hFFFF, ER);
    rd(8'h60, 16'h0000, ER);
    $display("test registers done");
    alarms <= '1;
    repeat (2) @(posedge aclk);
    `CHK(group_b_pin_powerdown_q, 4'h0)
    wr(oapd_pkg::PIN_EN_IDX, 16'h0005, OK);
    repeat (2) @(posedge aclk);
    `CHK(group_b_pin_powerdown_q, 4'h5)
    for (int i = 0; i < 12; i++) begin
      wr(oapd_pkg::SRC0_IDX, 16'h0000, OK);
      wr(oapd_pkg::SRC1_IDX, 16'h0000, OK);
      alarms <= 12'h1 << i;
      repeat (2) @(posedge aclk);
      `CHK(group_b_pin_powerdown_q, 4'h0)
      wr(i < 5 ? oapd_pkg::SRC0_IDX : oapd_pkg::SRC1_IDX,
        16'h1 << pos[i], OK);
      repeat (2) @(posedge aclk);
      `CHK(group_b_pin_powerdown_q, 4'h5)
      rd(oapd_pkg::ALARM_IDX, 16'h1 << i, OK);
      alarms <= '0;
      repeat (2) @(posedge aclk);
      `CHK(group_b_pin_powerdown_q, 4'h0)
    end
    $display("test alarm selection done");
    wr(oapd_pkg::IRQ_STAT_IDX, 16'h0FFF, OK);
    rd(oapd_pkg::IRQ_STAT_IDX, 16'h0000, OK);
    alarms <= 12'h004;
    @(posedge aclk);
    alarms <= '0;
    repeat (2) @(posedge aclk);
    `CHK(irq_q, 1'h0)
    rd(oapd_pkg::IRQ_STAT_IDX, 16'h0004, OK);
    wr(oapd_pkg::IRQ_MASK_IDX, 16'h0004, OK);
    repeat (2) @(posedge aclk);
    `CHK(irq_q, 1'h1)
    wr(oapd_pkg::IRQ_STAT_IDX, 16'h0004, OK);
    repeat (2) @(posedge aclk);
    `CHK(irq_q, 1'h0)
    rd(oapd_pkg::IRQ_STAT_IDX, 16'h0000, OK);
    $display("test interrupt done");
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(oapd_pkg::SRC1_IDX, 16'h1833, OK);
    rd(oapd_pkg::PIN_EN_IDX, 16'h0000, OK);
    `CHK(group_b_pin_powerdown_q, 4'h0)
    $display("test reset done");
    print_verdict();
  end
endmodule
